// File: shared/tlpc_defines.svh
// constants for the torque limit / push control block
`ifndef TLPC_DEFINES_SVH
`define TLPC_DEFINES_SVH

`define TLPC_ADDR_CTRL 8'h00
`define TLPC_ADDR_DATA 8'h04
`define TLPC_ADDR_MAP 8'h08
`define TLPC_ADDR_STAT 8'h0C
`define TLPC_ADDR_TPDO 8'h10

`define TLPC_CTRL_REQ 0
`define TLPC_CTRL_PUSH 1
`define TLPC_STAT_LIMIT 0
`define TLPC_STAT_REQ 1
`define TLPC_TPDO_BIT 12

`define TLPC_MAP_BUS_BIT_LSB 0
`define TLPC_MAP_BUS_EN 3
`define TLPC_MAP_LIM_IN_LSB 4
`define TLPC_MAP_REQ_OUT_LSB 8
`define TLPC_MAP_SEL0_LSB 12
`define TLPC_MAP_SEL1_LSB 16
`define TLPC_MAP_SEL2_LSB 20
`define TLPC_MAP_REQ_IN_LSB 24

`define TLPC_MAP_RESET 32'h0000_0000
`define TLPC_SEL_MAX_TORQUE 3'h3
`define TLPC_SEL_MAX_PUSH 3'h7

`endif

// File: shared/tlpc_pkg.sv
// types for the torque limit / push control block
package tlpc_pkg;
    typedef enum logic [2:0] {
        TLPC_SRC_NONE = 3'b001,
        TLPC_SRC_CMD = 3'b010,
        TLPC_SRC_PIN = 3'b100
    } tlpc_src_t;
endpackage : tlpc_pkg

// File: logic/tlpc_core.sv
// torque limit and push-motion control with apb register access
`timescale 1ns/1ps
`include "tlpc_defines.svh"

module tlpc_core #(
    parameter int NPORT = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPORT:1] din,
    input wire logic [NPORT:1] io_in,
    input wire logic [7:0] rpdo_byte0,
    input wire logic rpdo_valid,
    input wire logic torque_300pct,
    output logic [NPORT:1] dout,
    output logic limit_reached,
    output logic [15:0] tpdo_bytes01,
    output logic [2:0] src_last
);
    // port fetch: zero means unassigned
    function automatic logic pick(input logic [NPORT:1] v, input logic [3:0] p);
        pick = (p != 4'h0 && 32'(p) <= NPORT) ? v[p] : 1'b0;
    endfunction : pick

    logic [31:0] ctrl;
    logic [2:0] drive_data_select;
    logic [31:0] map;
    logic limit_push_request;
    logic sync1;
    logic sync2;
    logic pin_q;
    logic bus_q;
    tlpc_pkg::tlpc_src_t src;

    wire logic [3:0] lim_in_port = map[`TLPC_MAP_LIM_IN_LSB +: 4];
    wire logic [3:0] req_in_port = map[`TLPC_MAP_REQ_IN_LSB +: 4];
    wire logic [3:0] req_out_port = map[`TLPC_MAP_REQ_OUT_LSB +: 4];
    wire logic [3:0] sel0_port = map[`TLPC_MAP_SEL0_LSB +: 4];
    wire logic [3:0] sel1_port = map[`TLPC_MAP_SEL1_LSB +: 4];
    wire logic [3:0] sel2_port = map[`TLPC_MAP_SEL2_LSB +: 4];
    wire logic [2:0] bus_bit = map[`TLPC_MAP_BUS_BIT_LSB +: 3];
    wire logic bus_map_en = map[`TLPC_MAP_BUS_EN];
    // request output not overridden by a select line
    wire logic req_port_alone = req_out_port != sel0_port && req_out_port != sel1_port
        && req_out_port != sel2_port;
    wire logic push_mode = ctrl[`TLPC_CTRL_PUSH];
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic wr_ctrl = wr && paddr == `TLPC_ADDR_CTRL;
    wire logic wr_data = wr && paddr == `TLPC_ADDR_DATA;
    wire logic wr_map = wr && paddr == `TLPC_ADDR_MAP;
    wire logic known = paddr == `TLPC_ADDR_CTRL || paddr == `TLPC_ADDR_DATA || paddr == `TLPC_ADDR_MAP
        || paddr == `TLPC_ADDR_STAT || paddr == `TLPC_ADDR_TPDO;
    wire logic [2:0] sel_max = push_mode ? `TLPC_SEL_MAX_PUSH : `TLPC_SEL_MAX_TORQUE;
    wire logic pin_now = pick(io_in, req_in_port);
    wire logic bus_now = bus_map_en && rpdo_byte0[bus_bit];
    wire logic pin_edge = pin_now != pin_q;
    wire logic bus_edge = rpdo_valid && bus_now != bus_q;
    // driver limit condition line after sync, or 300 percent torque taken directly without sync
    wire logic limit_in = pick(din, lim_in_port);
    wire logic next_limit = sync2 || torque_300pct;
    // latest writer wins; bus and pin same cycle: bus wins, first in order below
    wire logic next_req = bus_edge ? bus_now : pin_edge ? pin_now : wr_ctrl ? pwdata[`TLPC_CTRL_REQ]
        : limit_push_request;
    wire logic [2:0] next_sel = (wr_data && pwdata[2:0] <= sel_max) ? pwdata[2:0] : drive_data_select;

    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        unique case (paddr)
            `TLPC_ADDR_CTRL: rd = {30'h0, push_mode, limit_push_request};
            `TLPC_ADDR_DATA: rd = {29'h0, drive_data_select};
            `TLPC_ADDR_MAP: rd = map;
            `TLPC_ADDR_STAT: rd = {30'h0, limit_push_request, limit_reached};
            `TLPC_ADDR_TPDO: rd = {16'h0, tpdo_bytes01};
            default: rd = 32'h0000_0000;
        endcase
    end

    // connector output builder
    logic [NPORT:1] next_dout;
    always_comb begin
        next_dout = '0;
        for (int i = 1; i <= NPORT; i++) begin
            if (req_out_port == 4'(i)) next_dout[i] = next_req;
            if (sel0_port == 4'(i)) next_dout[i] = next_sel[0];
            if (sel1_port == 4'(i)) next_dout[i] = next_sel[1];
            if (sel2_port == 4'(i)) next_dout[i] = next_sel[2] && push_mode;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= 32'h0000_0000;
            drive_data_select <= 3'h0;
            map <= `TLPC_MAP_RESET;
            limit_push_request <= 1'b0;
            src <= tlpc_pkg::TLPC_SRC_NONE;
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            pin_q <= 1'b0;
            bus_q <= 1'b0;
            dout <= '0;
            limit_reached <= 1'b0;
            tpdo_bytes01 <= 16'h0000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl <= {30'h0, pwdata[`TLPC_CTRL_PUSH], 1'b0};
            drive_data_select <= next_sel;
            if (wr_map) map <= pwdata;
            limit_push_request <= next_req;
            if (bus_edge) src <= tlpc_pkg::TLPC_SRC_PIN;
            else if (pin_edge) src <= tlpc_pkg::TLPC_SRC_PIN;
            else if (wr_ctrl) src <= tlpc_pkg::TLPC_SRC_CMD;
            sync1 <= limit_in;
            sync2 <= sync1;
            pin_q <= pin_now;
            if (rpdo_valid) bus_q <= bus_now;
            dout <= next_dout;
            limit_reached <= next_limit;
            tpdo_bytes01 <= {3'h0, next_limit, 12'h000};
            prdata <= (psel && !penable && !pwrite) ? rd : prdata;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
        end
    end

    assign src_last = src;

    // checks
    a_req_binary: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ctrl && !pin_edge && !bus_edge |=> limit_push_request == $past(pwdata[`TLPC_CTRL_REQ]))
        else $error("request not taken from command");
    a_pin_wins: assert property (@(posedge clock) disable iff (!rst_n)
        pin_edge && !bus_edge |=> limit_push_request == $past(pin_now))
        else $error("pin change lost");
    a_bus_wins: assert property (@(posedge clock) disable iff (!rst_n)
        bus_edge |=> limit_push_request == $past(bus_now))
        else $error("fieldbus change lost");
    a_req_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !wr_ctrl && !pin_edge && !bus_edge |=> limit_push_request == $past(limit_push_request))
        else $error("request changed with no source");
    a_limit_sync: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(limit_in) && !torque_300pct ##1 !torque_300pct ##1 !torque_300pct ##0 limit_in |=> limit_reached)
        else $error("limit not seen after sync");
    a_torque_over: assert property (@(posedge clock) disable iff (!rst_n)
        torque_300pct |=> limit_reached)
        else $error("overload torque not reported");
    a_tpdo_bit: assert property (@(posedge clock) disable iff (!rst_n)
        tpdo_bytes01 == {3'h0, limit_reached, 12'h000})
        else $error("transmit bit differs from output");
    a_sel_accept: assert property (@(posedge clock) disable iff (!rst_n)
        wr_data && pwdata[2:0] <= sel_max |=> drive_data_select == $past(pwdata[2:0]))
        else $error("data select write lost");
    a_sel_torque: assert property (@(posedge clock) disable iff (!rst_n)
        wr_data && !push_mode && pwdata[2:0] > `TLPC_SEL_MAX_TORQUE
        |=> drive_data_select == $past(drive_data_select))
        else $error("torque data range violated");
    a_unmapped_pin: assert property (@(posedge clock) disable iff (!rst_n)
        req_in_port == 4'h0 |-> !pin_now)
        else $error("unassigned input acted");
    a_unmapped_out: assert property (@(posedge clock) disable iff (!rst_n)
        $past(map[`TLPC_MAP_REQ_OUT_LSB +: 16]) == 16'h0000 |-> dout == '0)
        else $error("unassigned output driven");
    a_req_out_pin: assert property (@(posedge clock) disable iff (!rst_n)
        $past(req_out_port) != 4'h0 && $past(req_port_alone)
        |-> pick(dout, $past(req_out_port)) == limit_push_request)
        else $error("request output differs from request");
    a_apb_ready: assert property (@(posedge clock) disable iff (!rst_n)
        psel && !penable |=> pready) else $error("no ready after setup");
    a_apb_error: assert property (@(posedge clock) disable iff (!rst_n)
        psel && !penable && !known |=> pslverr) else $error("no error for unmapped address");
    c_req_cmd: cover property (@(posedge clock) disable iff (!rst_n) wr_ctrl && pwdata[0]);
    c_req_pin: cover property (@(posedge clock) disable iff (!rst_n) pin_edge);
    c_req_bus: cover property (@(posedge clock) disable iff (!rst_n) bus_edge);
    c_limit: cover property (@(posedge clock) disable iff (!rst_n) $rose(limit_reached));
    c_push_limit: cover property (@(posedge clock) disable iff (!rst_n)
        push_mode && limit_push_request && $rose(limit_reached));
endmodule : tlpc_core

// File: verif/tlpc_drv_model.sv
// motor driver model: raises its limit condition while the request is on and the load pushes back
`timescale 1ns/1ps
module tlpc_drv_model #(
    parameter int NPORT = 8,
    parameter int LIM_PORT = 3,
    parameter int REQ_PORT = 4
) (
    input wire logic clock,
    input wire logic [NPORT:1] dout,
    input wire logic load,
    output logic [NPORT:1] din
);
    logic lim_q = 1'b0;
    // limit condition only while limiting is requested and the load resists
    always @(posedge clock) lim_q <= dout[REQ_PORT] & load;
    always_comb begin
        din = '0;
        din[LIM_PORT] = lim_q;
    end
endmodule : tlpc_drv_model

// File: verif/tb_torque_limit_push_control.sv
// self-checking bench for the torque limit / push control block
`timescale 1ns/1ps
module tb_torque_limit_push_control;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, rpdo_valid = 0, torque_300pct = 0, drv_load = 0;
    logic [7:0] paddr = '0, rpdo_byte0 = '0;
    logic [31:0] pwdata = '0, prdata, rv;
    logic pready, pslverr, limit_reached, ev;
    logic [8:1] din, dout, io_in = '0;
    logic [15:0] tpdo_bytes01;
    logic [2:0] src_last;
    int mismatches = 0, tests_run = 0;
    always #25 clock = ~clock;
    tlpc_core #(.NPORT(8)) dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
        .io_in(io_in), .rpdo_byte0(rpdo_byte0), .rpdo_valid(rpdo_valid), .torque_300pct(torque_300pct),
        .dout(dout), .limit_reached(limit_reached), .tpdo_bytes01(tpdo_bytes01), .src_last(src_last));
    tlpc_drv_model #(.NPORT(8)) drv (.clock(clock), .dout(dout), .load(drv_load), .din(din));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, '0);
        chk(rv, exp);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        wt(16);
        rst_n <= 1;
        rd(8'h0C, 32'h0);
        rd(8'h00, 32'h0);
        chk(src_last, 3'b001);
        apb(1, 8'h08, 32'h0176_543A);
        apb(1, 8'h00, 32'h2);
        for (int i = 0; i < 8; i++) begin
            apb(1, 8'h04, i);
            wt(2);
            chk(dout[7:5], i);
        end
        apb(1, 8'h00, 32'h0);
        apb(1, 8'h04, 32'h5);
        rd(8'h04, 32'h7);
        wt(2);
        chk(dout[7:5], 3'h3);
        $display("select test done");
        apb(1, 8'h00, 32'h1);
        wt(2);
        chk(dout[4], 1'b1);
        chk(src_last, 3'b010);
        drv_load <= 1;
        wt(6);
        chk(limit_reached, 1'b1);
        chk(tpdo_bytes01, 16'h1000);
        rd(8'h0C, 32'h3);
        rd(8'h10, 32'h0000_1000);
        io_in <= 8'h01;
        wt(3);
        chk(src_last, 3'b100);
        io_in <= 8'h00;
        wt(3);
        chk(dout[4], 1'b0);
        wt(6);
        chk(limit_reached, 1'b0);
        rpdo_byte0 <= 8'h04;
        rpdo_valid <= 1;
        wt(1);
        rpdo_valid <= 0;
        wt(3);
        rd(8'h00, 32'h1);
        apb(1, 8'h00, 32'h0);
        rd(8'h00, 32'h0);
        chk(src_last, 3'b010);
        $display("source test done");
        torque_300pct <= 1;
        wt(3);
        chk(limit_reached, 1'b1);
        torque_300pct <= 0;
        rd(8'h20, 32'h0);
        chk(ev, 1'b1);
        apb(1, 8'h08, 32'h0176_540A);
        apb(1, 8'h00, 32'h1);
        wt(8);
        chk(limit_reached, 1'b0);
        $display("limit test done");
        apb(1, 8'h08, 32'h0176_543A);
        apb(1, 8'h00, 32'h2);
        apb(1, 8'h04, 32'h6);
        apb(1, 8'h00, 32'h3);
        wt(8);
        chk(dout[7:4], 4'hD);
        chk(limit_reached, 1'b1);
        drv_load <= 0;
        apb(1, 8'h00, 32'h2);
        wt(8);
        chk(limit_reached, 1'b0);
        chk(dout[4], 1'b0);
        $display("push test done");
        apb(1, 8'h00, 32'h1);
        rst_n <= 0;
        wt(2);
        rst_n <= 1;
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h0);
        chk(dout, 8'h00);
        $display("reset test done");
        finish_test();
    end
    initial begin
        wt(5000);
        mismatches++;
        finish_test();
    end
endmodule : tb_torque_limit_push_control
